// *** core/sep_defines.svh ***
`ifndef SEP_DEFINES_SVH
`define SEP_DEFINES_SVH
`define SEP_PORT_OFFSET   8'h0A
`define SEP_DATA_BIT      7
`define SEP_STROBE_BIT    0
`define SEP_ADDR_BITS     6
`define SEP_WORD_BITS     16
`define SEP_OP_READ       2'h2
`define SEP_OP_WRITE      2'h1
`define SEP_OP_EXT        2'h0
`define SEP_EXT_ENABLE    2'h3
`define SEP_EXT_DISABLE   2'h0
`endif

// *** core/sep_pkg.sv ***
package sep_pkg;
  typedef enum logic [2:0] {
    SEP_IDLE,
    SEP_OPCODE,
    SEP_ADDR,
    SEP_WDATA,
    SEP_RDATA,
    SEP_WAIT_END
  } sep_state_t;
endpackage

// *** core/sep_word_mem.sv ***
`timescale 1ns/1ps
`default_nettype none
// ******************************
// Word store with registered read.
// ******************************
module sep_word_mem #(
  parameter int AW = 6,
  parameter int DW = 16
) (
  input  wire logic          ref_clk,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule
`default_nettype wire

// *** core/sep_port.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sep_defines.svh"
// Overview of operation
// - Bit 7 data, bit 0 strobe, rest ignored.
// - One bit per write, strobe held high.
// - Stores refused until write enable seen.
// - Enable persists across many stores.
// - Disable sequence turns stores off again.
// - Reads return bit 15 down to 0.
module sep_port #(
  parameter int ADDR_BITS = `SEP_ADDR_BITS,
  parameter int WORD_BITS = `SEP_WORD_BITS
) (
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  output logic            write_enabled,
  output logic            busy
);
  sep_pkg::sep_state_t state;
  sep_pkg::sep_state_t next_state;
  logic [4:0]           cnt;
  logic [4:0]           next_cnt;
  logic [1:0]           opcode;
  logic [1:0]           next_opcode;
  logic [ADDR_BITS-1:0] waddr;
  logic [ADDR_BITS-1:0] next_waddr;
  logic [WORD_BITS-1:0] shreg;
  logic [WORD_BITS-1:0] next_shreg;
  logic                 next_write_enabled;
  logic                 next_busy;
  logic [7:0]           next_rdata;
  logic                 mem_we;
  logic                 load_pending;
  logic                 next_load_pending;
  logic [WORD_BITS-1:0] mem_q;

  logic                 port_wr;
  logic                 port_rd;
  logic                 sbit;
  logic                 strobe;
  logic                 frame_end;
  logic [1:0]           ext_code;

  // ******************************
  // Port decode.
  // ******************************
  assign port_wr = wr && (addr == `SEP_PORT_OFFSET);
  assign port_rd = rd && (addr == `SEP_PORT_OFFSET);
  assign sbit    = wdata[`SEP_DATA_BIT];
  assign strobe  = wdata[`SEP_STROBE_BIT];

  // A closing byte only takes effect when it follows a frame of exactly the right length.
  assign frame_end = port_wr && !strobe && (state == sep_pkg::SEP_WAIT_END) && (cnt == 5'h00);
  assign ext_code  = waddr[ADDR_BITS-1 -: 2];
  assign mem_we    = frame_end && (opcode == `SEP_OP_WRITE) && write_enabled;

  // ******************************
  // Calibration word store.
  // ******************************
  // The read side looks at the address the shift register is about to hold, so the
  // word is ready one cycle after the last address bit rather than a cycle late.
  sep_word_mem #(
    .AW (ADDR_BITS),
    .DW (WORD_BITS)
  ) u_mem (
    .ref_clk (ref_clk),
    .wr_en   (mem_we),
    .wr_addr (waddr),
    .wr_data (shreg),
    .rd_addr (next_waddr),
    .rd_data (mem_q)
  );

  // ******************************
  // Frame sequencer.
  // ******************************
  always_comb begin
    next_state         = state;
    next_cnt           = cnt;
    next_opcode        = opcode;
    next_waddr         = waddr;
    next_shreg         = shreg;
    next_load_pending  = 1'b0;
    if (load_pending) begin
      next_shreg = mem_q;
    end
    if (port_wr && !strobe) begin
      // Any byte with the strobe low ends a frame, whether or not it was complete.
      next_state = sep_pkg::SEP_IDLE;
      next_cnt   = 5'h00;
    end else if (port_wr) begin
      unique case (state)
        sep_pkg::SEP_IDLE: begin
          if (sbit) begin
            next_state = sep_pkg::SEP_OPCODE;
            next_cnt   = 5'h00;
          end
        end
        sep_pkg::SEP_OPCODE: begin
          next_opcode = {opcode[0], sbit};
          next_cnt    = cnt + 5'h01;
          if (cnt == 5'h01) begin
            next_state = sep_pkg::SEP_ADDR;
            next_cnt   = 5'h00;
          end
        end
        sep_pkg::SEP_ADDR: begin
          next_waddr = {waddr[ADDR_BITS-2:0], sbit};
          next_cnt   = cnt + 5'h01;
          if (cnt == 5'(ADDR_BITS - 1)) begin
            next_cnt = 5'h00;
            if (opcode == `SEP_OP_WRITE) begin
              next_state = sep_pkg::SEP_WDATA;
            end else if (opcode == `SEP_OP_READ) begin
              next_state        = sep_pkg::SEP_RDATA;
              next_load_pending = 1'b1;
            end else begin
              next_state = sep_pkg::SEP_WAIT_END;
            end
          end
        end
        sep_pkg::SEP_WDATA: begin
          next_shreg = {shreg[WORD_BITS-2:0], sbit};
          next_cnt   = cnt + 5'h01;
          if (cnt == 5'(WORD_BITS - 1)) begin
            next_state = sep_pkg::SEP_WAIT_END;
            next_cnt   = 5'h00;
          end
        end
        sep_pkg::SEP_RDATA: begin
        end
        sep_pkg::SEP_WAIT_END: begin
          // An extra bit makes the frame malformed; it will be dropped.
          next_cnt = 5'h01;
        end
      endcase
    end else if (port_rd && state == sep_pkg::SEP_RDATA && !load_pending) begin
      next_shreg = {shreg[WORD_BITS-2:0], 1'b0};
      next_cnt   = cnt + 5'h01;
      if (cnt == 5'(WORD_BITS - 1)) begin
        next_state = sep_pkg::SEP_WAIT_END;
        next_cnt   = 5'h00;
      end
    end
    next_busy = (next_state != sep_pkg::SEP_IDLE);
  end

  // ******************************
  // Sequencer registers.
  // ******************************
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state         <= sep_pkg::SEP_IDLE;
      cnt           <= 5'h00;
      opcode        <= 2'h0;
      waddr         <= '0;
      shreg         <= '0;
      busy          <= 1'b0;
      load_pending  <= 1'b0;
    end else begin
      state         <= next_state;
      cnt           <= next_cnt;
      opcode        <= next_opcode;
      waddr         <= next_waddr;
      shreg         <= next_shreg;
      busy          <= next_busy;
      load_pending  <= next_load_pending;
    end
  end

  // ******************************
  // Store permission flag.
  // ******************************
  // Only a complete extended frame moves the flag; other extended codes leave it alone.
  always_comb begin
    next_write_enabled = write_enabled;
    if (frame_end && (opcode == `SEP_OP_EXT)) begin
      if (ext_code == `SEP_EXT_ENABLE) begin
        next_write_enabled = 1'b1;
      end else if (ext_code == `SEP_EXT_DISABLE) begin
        next_write_enabled = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      write_enabled <= 1'b0;
    end else begin
      write_enabled <= next_write_enabled;
    end
  end

  // ******************************
  // Read data register.
  // ******************************
  // A read in the word load cycle, or outside the data phase, shows the bit that is
  // already waiting; only the sequencer decides whether the word advances.
  always_comb begin
    next_rdata = 8'h00;
    if (port_rd) begin
      // Bit 7 shows the current word bit; the other bits read zero.
      next_rdata = {shreg[WORD_BITS-1], 7'h00};
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else begin
      rdata <= next_rdata;
    end
  end
endmodule
`default_nettype wire

// *** dv/sep_port_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module sep_port_asserts (
  input wire logic       ref_clk,
  input wire logic       rstn,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic [7:0] rdata,
  input wire logic       rd,
  input wire logic       write_enabled,
  input wire logic       busy
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  wire take_wr = wr && addr == 8'h0A;
  sequence end_write;
    take_wr && !wdata[0];
  endsequence
  chk_read_bit_only: assert property (rdata[6:0] == 7'h00)
    else $error("rdata low bits set");
  chk_rdata_needs_rd: assert property (!(rd && addr == 8'h0A) |=> rdata == 8'h00)
    else $error("rdata without read");
  chk_enable_cause: assert property (!(take_wr && !wdata[0]) |=> !$rose(write_enabled))
    else $error("enable rose without end write");
  chk_disable_cause: assert property (!(take_wr && !wdata[0]) |=> !$fell(write_enabled))
    else $error("enable fell without end write");
  chk_enable_holds: assert property (!wr |=> $stable(write_enabled))
    else $error("enable changed without write");
  chk_busy_open: assert property (!take_wr |=> !$rose(busy))
    else $error("frame opened without write");
  chk_frame_close: assert property (end_write |=> !busy)
    else $error("frame open after end write");
endmodule
bind sep_port sep_port_asserts u_chk (.ref_clk(ref_clk), .rstn(rstn), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .write_enabled(write_enabled), .busy(busy));
`default_nettype wire

// *** dv/sep_host.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****
// Host that frames commands one bit per byte.
// ****
module sep_host (
  input  wire logic       ref_clk,
  input  wire logic [7:0] rdata,
  output logic      [7:0] addr,
  output logic      [7:0] wdata,
  output logic            wr,
  output logic            rd
);
  initial begin
    addr = 8'h0A;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end
  task automatic put(input logic [7:0] b);
    @(posedge ref_clk);
    wdata <= b;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task automatic bits(input logic [23:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      put(v[i] ? 8'h81 : 8'h01);
    end
  endtask
  task automatic store(input logic [5:0] a, input logic [15:0] d);
    put(8'h81);
    bits({2'b01, a, d}, 24);
    put(8'h00);
  endtask
  task automatic command(input logic [7:0] v);
    put(8'h81);
    bits({16'h0000, v}, 8);
    put(8'h00);
  endtask
  task automatic fetch(input logic [5:0] a, output logic [15:0] d);
    put(8'h81);
    bits({16'h0000, 2'b10, a}, 8);
    for (int i = 15; i >= 0; i--) begin
      @(posedge ref_clk);
      rd <= 1'b1;
      @(posedge ref_clk);
      rd <= 1'b0;
      @(negedge ref_clk);
      d[i] = rdata[7];
    end
    put(8'h00);
  endtask
endmodule
`default_nettype wire

// *** dv/serial_eeprom_bitbang_port_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_bitbang_port_test;
  logic        ref_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  addr, wdata, rdata;
  logic        wr, rd, write_enabled, busy;
  logic [15:0] got;
  int          fail_count = 0;
  int          tests_run = 0;
  always #2 ref_clk = ~ref_clk;
  sep_port u_dut (.ref_clk(ref_clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .write_enabled(write_enabled), .busy(busy));
  sep_host u_host (.ref_clk(ref_clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd));
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] seen);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
    $display("test %s done", name);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    u_host.command(8'h30);
    repeat (2) @(negedge ref_clk);
    check("enable", 16'h0001, {15'h0000, write_enabled});
    u_host.store(6'h05, 16'hAA55);
    u_host.store(6'h04, 16'h1234);
    u_host.fetch(6'h05, got);
    check("word5", 16'hAA55, got);
    u_host.fetch(6'h04, got);
    check("word4", 16'h1234, got);
    u_host.put(8'h81);
    u_host.bits({14'h0000, 2'b01, 6'h05, 2'b00}, 10);
    u_host.put(8'h00);
    u_host.fetch(6'h05, got);
    check("aborted", 16'hAA55, got);
    u_host.command(8'h00);
    repeat (2) @(negedge ref_clk);
    check("disable", 16'h0000, {15'h0000, write_enabled});
    u_host.store(6'h05, 16'h0F0F);
    u_host.fetch(6'h05, got);
    check("refused", 16'hAA55, got);
    @(negedge ref_clk);
    check("idle", 16'h0000, {15'h0000, busy});
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    @(negedge ref_clk);
    check("reset", 16'h0000, {15'h0000, write_enabled});
    u_host.store(6'h04, 16'h5A5A);
    u_host.fetch(6'h04, got);
    check("locked", 16'h1234, got);
    give_verdict();
  end
endmodule
`default_nettype wire
